// ---- core/pmc_power_mode_controller.sv ----
module pmc_power_mode_controller (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output      logic [31:0]           reg_rdata,
  input  wire logic                  wakeup_evt,
  input  wire logic                  rtc_irq,
  input  wire logic                  reset_pin_n,
  input  wire logic                  phy_interrupt_pin_n,
  input  wire logic                  power_good_input_n,
  output      pmc_pkg::pmc_clk_ctl_t clk_ctl,
  output      logic [5:0]            active_mult,
  output      logic                  external_wake_output,
  output      logic                  pins_oe,
  output      logic                  sdram_self_refresh,
  output      logic                  core_start,
  output      logic                  soft_reset_pulse
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1_reg <= 4'h7;
      sync2_reg <= 4'h7;
    end else begin
      sync1_reg <= {rtc_irq, reset_pin_n, phy_interrupt_pin_n,
                    power_good_input_n};
      sync2_reg <= sync1_reg;
    end
  end

  logic rtc_s;
  logic rst_pin_s_n;
  logic phy_s_n;
  logic pg_s_n;
  logic rst_pin_q_reg;
  logic rtc_q_reg;
  logic rst_fall;
  logic rtc_rise;

  assign rtc_s       = sync2_reg[3];
  assign rst_pin_s_n = sync2_reg[2];
  assign phy_s_n     = sync2_reg[1];
  assign pg_s_n      = sync2_reg[0];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rst_pin_q_reg <= 1'b1;
      rtc_q_reg     <= 1'b0;
    end else begin
      rst_pin_q_reg <= rst_pin_s_n;
      rtc_q_reg     <= rtc_s;
    end
  end

  assign rst_fall = rst_pin_q_reg & ~rst_pin_s_n;
  assign rtc_rise = rtc_s & ~rtc_q_reg;

  // ****************************************************************
  // register port decode
  // ****************************************************************
  logic        wr_synth;
  logic        wr_reg;
  logic        wr_req;
  logic [2:0]  req_code;
  pmc_pkg::pmc_mode_t mode_reg;
  pmc_pkg::pmc_mode_t mode_next;
  logic        hib_wake;

  assign wr_synth = reg_wr && reg_addr == pmc_pkg::SYNTH_CTL_OFS;
  assign wr_reg   = reg_wr && reg_addr == pmc_pkg::REG_CTL_OFS;
  assign wr_req   = reg_wr && reg_addr == pmc_pkg::MODE_REQ_OFS;
  assign req_code = wr_req ? reg_wdata[2:0] : 3'h0;

  // ****************************************************************
  // synthesiser control: lost across hibernate
  // ****************************************************************
  logic [31:0] synth_ctl_reg;
  logic [31:0] reg_ctl_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n || hib_wake) begin
      synth_ctl_reg <= pmc_pkg::SYNTH_CTL_RST;
    end else if (wr_synth) begin
      synth_ctl_reg <= reg_wdata;
    end
  end

  // regulator control survives hibernate wakeup
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_ctl_reg <= pmc_pkg::REG_CTL_RST;
    end else if (wr_reg) begin
      reg_ctl_reg <= reg_wdata;
    end
  end

  logic       synth_en_sw;
  logic       synth_byp_sw;
  logic [5:0] mult_sw;
  logic       level_off;

  assign synth_en_sw  = synth_ctl_reg[pmc_pkg::SYNTH_EN_BIT];
  assign synth_byp_sw = synth_ctl_reg[pmc_pkg::SYNTH_BYP_BIT];
  assign mult_sw      = synth_ctl_reg[pmc_pkg::SYNTH_MULT_LSB +:
                                      pmc_pkg::SYNTH_MULT_W];
  assign level_off    = reg_ctl_reg[pmc_pkg::REG_LEVEL_LSB +:
                                    pmc_pkg::REG_LEVEL_W]
                        == pmc_pkg::REG_LEVEL_OFF;

  // ****************************************************************
  // hibernate wake sources
  // ****************************************************************
  assign hib_wake = mode_reg == pmc_pkg::PMC_HIBERNATE &&
    ((reg_ctl_reg[pmc_pkg::WAKE_PHY_BIT] && !phy_s_n) ||
     (reg_ctl_reg[pmc_pkg::WAKE_RTC_BIT] && rtc_rise) ||
     (reg_ctl_reg[pmc_pkg::WAKE_RST_BIT] && rst_fall));

  // ****************************************************************
  // mode state machine
  // ****************************************************************
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      pmc_pkg::PMC_FULL_ON: begin
        if (req_code == pmc_pkg::REQ_ACTIVE) begin
          mode_next = pmc_pkg::PMC_ACTIVE;
        end else if (req_code == pmc_pkg::REQ_SLEEP) begin
          mode_next = pmc_pkg::PMC_SLEEP;
        end else if (req_code == pmc_pkg::REQ_DEEP) begin
          mode_next = pmc_pkg::PMC_DEEP;
        end else if (req_code == pmc_pkg::REQ_HIB && level_off) begin
          mode_next = pmc_pkg::PMC_HIBERNATE;
        end
      end
      pmc_pkg::PMC_ACTIVE: begin
        // full-on and sleep need the synthesiser running again
        if (req_code == pmc_pkg::REQ_FULL && synth_en_sw) begin
          mode_next = pmc_pkg::PMC_FULL_ON;
        end else if (req_code == pmc_pkg::REQ_SLEEP && synth_en_sw) begin
          mode_next = pmc_pkg::PMC_SLEEP;
        end else if (req_code == pmc_pkg::REQ_DEEP) begin
          mode_next = pmc_pkg::PMC_DEEP;
        end else if (req_code == pmc_pkg::REQ_HIB && level_off) begin
          mode_next = pmc_pkg::PMC_HIBERNATE;
        end
      end
      pmc_pkg::PMC_SLEEP: begin
        if (wakeup_evt || rtc_rise) begin
          mode_next = synth_byp_sw ? pmc_pkg::PMC_ACTIVE
                                   : pmc_pkg::PMC_FULL_ON;
        end
      end
      pmc_pkg::PMC_DEEP: begin
        if (rst_fall) begin
          mode_next = pmc_pkg::PMC_FULL_ON;
        end else if (rtc_rise) begin
          mode_next = pmc_pkg::PMC_ACTIVE;
        end
      end
      pmc_pkg::PMC_HIBERNATE: begin
        if (hib_wake) begin
          mode_next = pmc_pkg::PMC_WAIT_PG;
        end
      end
      pmc_pkg::PMC_WAIT_PG: begin
        if (!pg_s_n) begin
          mode_next = pmc_pkg::PMC_FULL_ON;
        end
      end
      default: begin
        mode_next = pmc_pkg::PMC_FULL_ON;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_reg <= pmc_pkg::PMC_WAIT_PG;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ****************************************************************
  // clock gating, registered from mode_next; synth_en in active mode also follows synth_en_sw
  // ****************************************************************
  pmc_pkg::pmc_clk_ctl_t clk_next;

  always_comb begin
    clk_next = '0;
    case (mode_next)
      pmc_pkg::PMC_FULL_ON: begin
        clk_next = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
      end
      pmc_pkg::PMC_ACTIVE: begin
        clk_next = '{synth_en_sw, 1'b1, 1'b1, 1'b1, 1'b1};
      end
      pmc_pkg::PMC_SLEEP: begin
        clk_next = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
      end
      pmc_pkg::PMC_DEEP: begin
        clk_next = '0;
      end
      default: begin
        clk_next = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      clk_ctl <= '0;
    end else begin
      clk_ctl <= clk_next;
    end
  end

  // multiplier latched only on entry to full-on
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      active_mult <= pmc_pkg::MULT_RST;
    end else if (mode_next == pmc_pkg::PMC_FULL_ON &&
                 mode_reg != pmc_pkg::PMC_FULL_ON) begin
      active_mult <= mult_sw;
    end
  end

  // ****************************************************************
  // pins toward regulator, sdram and pads
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      external_wake_output <= 1'b1;
      pins_oe              <= 1'b0;
      sdram_self_refresh   <= 1'b0;
      core_start           <= 1'b0;
      soft_reset_pulse     <= 1'b0;
    end else begin
      external_wake_output <= !(level_off &&
                               mode_next == pmc_pkg::PMC_HIBERNATE)
                              || hib_wake;
      pins_oe              <= mode_next != pmc_pkg::PMC_HIBERNATE;
      sdram_self_refresh   <= reg_ctl_reg[pmc_pkg::SDRAM_RET_BIT] &&
                              (mode_next == pmc_pkg::PMC_HIBERNATE ||
                               mode_next == pmc_pkg::PMC_WAIT_PG);
      core_start           <= mode_next != pmc_pkg::PMC_WAIT_PG &&
                              mode_next != pmc_pkg::PMC_HIBERNATE;
      soft_reset_pulse     <= hib_wake;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        pmc_pkg::SYNTH_CTL_OFS: reg_rdata <= synth_ctl_reg;
        pmc_pkg::REG_CTL_OFS:   reg_rdata <= reg_ctl_reg;
        pmc_pkg::STATUS_OFS: begin
          reg_rdata <= {24'h0000_00, pg_s_n, clk_ctl.synth_en,
                        active_mult[5:3], mode_reg};
        end
        default:                reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule // pmc_power_mode_controller

// ---- include/pmc_pkg.sv ----
package pmc_pkg;

  // ****************************************************************
  // register map (word offsets on the plain register port)
  // ****************************************************************
  localparam logic [3:0] SYNTH_CTL_OFS    = 4'h0;
  localparam logic [3:0] REG_CTL_OFS      = 4'h1;
  localparam logic [3:0] MODE_REQ_OFS     = 4'h2;
  localparam logic [3:0] STATUS_OFS       = 4'h3;

  // synth_control_register fields
  localparam int SYNTH_EN_BIT    = 0;
  localparam int SYNTH_BYP_BIT   = 1;
  localparam int SYNTH_MULT_LSB  = 8;
  localparam int SYNTH_MULT_W    = 6;

  // regulator_control_register fields
  localparam int REG_LEVEL_LSB   = 0;
  localparam int REG_LEVEL_W     = 2;
  localparam int WAKE_PHY_BIT    = 8;
  localparam int WAKE_RTC_BIT    = 9;
  localparam int WAKE_RST_BIT    = 10;
  localparam int SDRAM_RET_BIT   = 11;

  localparam logic [1:0]  REG_LEVEL_OFF   = 2'h0;
  localparam logic [31:0] SYNTH_CTL_RST   = 32'h0000_0601;
  localparam logic [31:0] REG_CTL_RST     = 32'h0000_0701;
  localparam logic [5:0]  MULT_RST        = 6'h06;

  // mode request codes written to MODE_REQ_OFS
  localparam logic [2:0] REQ_SLEEP   = 3'h1;
  localparam logic [2:0] REQ_DEEP    = 3'h2;
  localparam logic [2:0] REQ_HIB     = 3'h3;
  localparam logic [2:0] REQ_FULL    = 3'h4;
  localparam logic [2:0] REQ_ACTIVE  = 3'h5;

  typedef enum logic [2:0] {
    PMC_FULL_ON   = 3'b000,
    PMC_ACTIVE    = 3'b001,
    PMC_SLEEP     = 3'b010,
    PMC_DEEP      = 3'b011,
    PMC_HIBERNATE = 3'b100,
    PMC_WAIT_PG   = 3'b101
  } pmc_mode_t;

  typedef struct packed {
    logic synth_en;
    logic synth_bypass;
    logic core_clk_en;
    logic sys_clk_en;
    logic dma_l1_grant;
  } pmc_clk_ctl_t;

endpackage

// ---- test/pmc_chk.sv ----
module pmc_chk (
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic [3:0]            reg_addr,
  input wire logic [31:0]           reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [31:0]           reg_rdata,
  input wire logic                  power_good_input_n,
  input wire pmc_pkg::pmc_clk_ctl_t clk_ctl,
  input wire logic [5:0]            active_mult,
  input wire logic                  external_wake_output,
  input wire logic                  pins_oe,
  input wire logic                  core_start,
  input wire logic                  soft_reset_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence full_on_s;
    clk_ctl.synth_en && !clk_ctl.synth_bypass && clk_ctl.core_clk_en;
  endsequence
  // level field last written as zero
  logic lvl0_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lvl0_reg <= 1'b0;
    end else if (reg_wr && reg_addr == pmc_pkg::REG_CTL_OFS) begin
      lvl0_reg <= reg_wdata[1:0] == 2'h0;
    end
  end
  chk_rdata_idle: assert property (!$past(reg_rd) |->
    reg_rdata == 32'h0000_0000) else $error("read data not idle");
  chk_core_sys: assert property (clk_ctl.core_clk_en |->
    clk_ctl.sys_clk_en) else $error("core clock without system clock");
  chk_deep_stop: assert property (!clk_ctl.sys_clk_en |->
    !clk_ctl.synth_en && !clk_ctl.core_clk_en) else $error("deep clocks");
  chk_sleep_dma: assert property (clk_ctl.sys_clk_en &&
    !clk_ctl.core_clk_en |-> !clk_ctl.dma_l1_grant) else $error("sleep dma");
  chk_active_dma: assert property (clk_ctl.synth_bypass &&
    clk_ctl.core_clk_en |-> clk_ctl.dma_l1_grant) else $error("active dma");
  chk_level_wake: assert property (reg_wr && lvl0_reg &&
    reg_addr == pmc_pkg::MODE_REQ_OFS &&
    reg_wdata[2:0] == pmc_pkg::REQ_HIB && clk_ctl.core_clk_en
    |=> !external_wake_output) else $error("wake not lowered");
  chk_pins_core: assert property (!pins_oe |-> !core_start)
    else $error("core runs with pads off");
  chk_pg_start: assert property ($rose(core_start) |->
    !$past(power_good_input_n, 3)) else $error("start before power good");
  chk_pulse_one: assert property (soft_reset_pulse |=>
    !soft_reset_pulse && !core_start) else $error("reset pulse length");
  chk_mult_full: assert property ($changed(active_mult) &&
    pins_oe |-> ##[0:1] full_on_s) else $error("multiplier outside full-on");
endmodule // pmc_chk

bind pmc_power_mode_controller pmc_chk u_chk (
  .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .power_good_input_n, .clk_ctl, .active_mult, .external_wake_output,
  .pins_oe, .core_start, .soft_reset_pulse
);

// ---- test/pmc_power_mode_controller_bench.sv ----
module pmc_power_mode_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  ref_clk, rst_n, reg_wr, reg_rd, wakeup_evt, rtc_irq;
  logic                  reset_pin_n, phy_interrupt_pin_n, power_good_input_n;
  logic                  external_wake_output, pins_oe, sdram_self_refresh;
  logic                  core_start, soft_reset_pulse;
  logic [3:0]            reg_addr;
  logic [31:0]           reg_wdata, reg_rdata, d;
  logic [5:0]            active_mult;
  pmc_pkg::pmc_clk_ctl_t clk_ctl;
  int                    n_mismatch = 0;
  int                    n_tests = 0;

  pmc_power_mode_controller uut (
    .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .wakeup_evt, .rtc_irq, .reset_pin_n, .phy_interrupt_pin_n,
    .power_good_input_n, .clk_ctl, .active_mult, .external_wake_output,
    .pins_oe, .sdram_self_refresh, .core_start, .soft_reset_pulse
  );
  pmc_reg_model #(.RAMP(8)) u_reg (
    .ref_clk, .external_wake_output, .power_good_input_n
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e,
                     input string what);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e,
                    input string what);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
    if (what != "") chk(d, e, what);
  endtask
  task automatic req(input logic [2:0] m);
    wr(pmc_pkg::MODE_REQ_OFS, {29'h0, m});
    repeat (3) @(posedge ref_clk);
  endtask
  // mode code from status, then {synth_en, core, sys}
  task automatic mode(input pmc_pkg::pmc_mode_t m, input logic [2:0] ck);
    rc(pmc_pkg::STATUS_OFS, 32'h0, "");
    chk({29'h0, d[2:0]}, {29'h0, m}, "mode");
    chk({29'h0, clk_ctl.synth_en, clk_ctl.core_clk_en, clk_ctl.sys_clk_en},
        {29'h0, ck}, "clocks");
  endtask
  task automatic wait_hi(ref logic s, input string what);
    for (int i = 0; i < 200 && s !== 1'b1; i++) @(posedge ref_clk);
    chk({31'h0, s}, 32'h0000_0001, what);
  endtask
  // 0 wakeup_evt, 1 rtc_irq, 2 reset_pin_n (active low)
  task automatic pulse(input int k);
    @(posedge ref_clk);
    case (k)
      0: wakeup_evt <= 1'b1;
      1: rtc_irq <= 1'b1;
      default: reset_pin_n <= 1'b0;
    endcase
    repeat (6) @(posedge ref_clk);
    case (k)
      0: wakeup_evt <= 1'b0;
      1: rtc_irq <= 1'b0;
      default: reset_pin_n <= 1'b1;
    endcase
    repeat (4) @(posedge ref_clk);
  endtask
  task test_done;
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    test_done;
  end

  initial begin
    {rst_n, reg_wr, reg_rd, wakeup_evt, rtc_irq} = 5'h0;
    {reset_pin_n, phy_interrupt_pin_n, reg_addr, reg_wdata} = {2'h3, 36'h0};
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    wait_hi(core_start, "core_start");
    mode(pmc_pkg::PMC_FULL_ON, 3'h7);
    rc(pmc_pkg::SYNTH_CTL_OFS, pmc_pkg::SYNTH_CTL_RST, "synth");
    rc(pmc_pkg::REG_CTL_OFS, pmc_pkg::REG_CTL_RST, "regctl");
    rc(4'h7, 32'h0000_0000, "unmapped");
    wr(pmc_pkg::SYNTH_CTL_OFS, 32'h0000_0603);
    req(pmc_pkg::REQ_ACTIVE);
    mode(pmc_pkg::PMC_ACTIVE, 3'h7);
    chk({31'h0, clk_ctl.synth_bypass}, 32'h0000_0001, "bypass");
    // new multiplier, synthesiser off, full-on must be refused
    wr(pmc_pkg::SYNTH_CTL_OFS, 32'h0000_0C02);
    req(pmc_pkg::REQ_FULL);
    mode(pmc_pkg::PMC_ACTIVE, 3'h3);
    chk({31'h0, clk_ctl.dma_l1_grant}, 32'h0000_0001, "dma");
    chk({26'h0, active_mult}, {26'h0, pmc_pkg::MULT_RST}, "mult");
    wr(pmc_pkg::SYNTH_CTL_OFS, 32'h0000_0C01);
    req(pmc_pkg::REQ_SLEEP);
    mode(pmc_pkg::PMC_SLEEP, 3'h5);
    chk({31'h0, clk_ctl.dma_l1_grant}, 32'h0000_0000, "dma");
    pulse(0);
    mode(pmc_pkg::PMC_FULL_ON, 3'h7);
    chk({26'h0, active_mult}, 32'h0000_000C, "mult");
    req(pmc_pkg::REQ_DEEP);
    mode(pmc_pkg::PMC_DEEP, 3'h0);
    pulse(0);
    mode(pmc_pkg::PMC_DEEP, 3'h0);
    pulse(1);
    mode(pmc_pkg::PMC_ACTIVE, 3'h7);
    req(pmc_pkg::REQ_DEEP);
    pulse(2);
    mode(pmc_pkg::PMC_FULL_ON, 3'h7);
    // level off, phy wake only, sdram kept
    wr(pmc_pkg::REG_CTL_OFS, 32'h0000_0900);
    req(pmc_pkg::REQ_HIB);
    chk({31'h0, external_wake_output}, 32'h0000_0000, "wake");
    chk({31'h0, pins_oe}, 32'h0000_0000, "pins_oe");
    chk({31'h0, sdram_self_refresh}, 32'h0000_0001, "sdram");
    pulse(1);
    chk({31'h0, external_wake_output}, 32'h0000_0000, "wake");
    phy_interrupt_pin_n <= 1'b0;
    wait_hi(soft_reset_pulse, "reset pulse");
    chk({31'h0, core_start}, 32'h0000_0000, "core_start");
    phy_interrupt_pin_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk({31'h0, external_wake_output}, 32'h0000_0001, "wake");
    wait_hi(core_start, "core_start");
    rc(pmc_pkg::REG_CTL_OFS, 32'h0000_0900, "regctl");
    rc(pmc_pkg::SYNTH_CTL_OFS, pmc_pkg::SYNTH_CTL_RST, "synth");
    test_done;
  end
endmodule // pmc_power_mode_controller_bench

// ---- test/pmc_reg_model.sv ----
module pmc_reg_model #(
  parameter int RAMP = 8
) (
  input  wire logic ref_clk,
  input  wire logic external_wake_output,
  output logic      power_good_input_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial power_good_input_n = 1'b1;
  // supply collapses at once, ramps for RAMP cycles on wake
  always @(posedge ref_clk) begin
    if (!external_wake_output) begin
      cnt <= 0;
      power_good_input_n <= 1'b1;
    end else if (cnt < RAMP) begin
      cnt <= cnt + 1;
    end else begin
      power_good_input_n <= 1'b0;
    end
  end
endmodule // pmc_reg_model
